// File: rtl/odrs_pkg.sv
// How it works
// - each output keeps a 3-bit 6g de-emphasis code in bits 14:12 that resets to 2.
// - each output keeps a 3-bit 3g de-emphasis code in bits 11:9 that resets to 1.
// - each output keeps a 3-bit hd de-emphasis code in bits 8:6 that resets to 1.
// - each output keeps a 3-bit sd de-emphasis code in bits 5:3 that resets to 0 (no emphasis).
// - each output keeps a 3-bit audio-stream de-emphasis code in bits 2:0 that resets to 0.
// - output b has its own de-emphasis register with the same layout and resets as output a.
// - output a keeps a 4-bit hd swing code in bits 11:8 that resets to 3.
// - output a keeps a 4-bit sd swing code in bits 7:4 that resets to 3.
// - output a keeps a 4-bit audio swing code in bits 3:0 that resets to 3.
// - a 4-bit passthrough swing code in bits 15:12, reset 3, serves output a while unlocked.
// - in passthrough the passthrough swing code goes to the driver, not a rate code.
// - a silenced amplitude code in bits 11:8, reset 3, overrides all other swing codes on mute.
// - the passthrough register also holds 6g swing in bits 7:4 and 3g swing in 3:0, reset 3.
// - an output's off control overrides its silence control and turns the output fully off.
package odrs_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] ODRS_IDX_EMPH_A = 8'h1a;
  localparam logic [7:0] ODRS_IDX_EMPH_B = 8'h1b;
  localparam logic [7:0] ODRS_IDX_AMP_LOW = 8'h1c;
  localparam logic [7:0] ODRS_IDX_AMP_BYP = 8'h1d;
  localparam logic [7:0] ODRS_IDX_CTRL = 8'h20;
  localparam logic [7:0] ODRS_IDX_STAT = 8'h21;
  // de-emphasis field positions
  localparam int ODRS_EMPH_6G_LSB = 12;
  localparam int ODRS_EMPH_3G_LSB = 9;
  localparam int ODRS_EMPH_HD_LSB = 6;
  localparam int ODRS_EMPH_SD_LSB = 3;
  localparam int ODRS_EMPH_AUDIO_LSB = 0;
  // swing field positions
  localparam int ODRS_AMP_HD_LSB = 8;
  localparam int ODRS_AMP_SD_LSB = 4;
  localparam int ODRS_AMP_AUDIO_LSB = 0;
  localparam int ODRS_AMP_PASS_LSB = 12;
  localparam int ODRS_AMP_SIL_LSB = 8;
  localparam int ODRS_AMP_6G_LSB = 4;
  localparam int ODRS_AMP_3G_LSB = 0;
  // reset values and writable masks
  localparam logic [15:0] ODRS_EMPH_RST = 16'h2240;
  localparam logic [15:0] ODRS_EMPH_MASK = 16'h7fff;
  localparam logic [15:0] ODRS_AMP_LOW_RST = 16'h0333;
  localparam logic [15:0] ODRS_AMP_LOW_MASK = 16'h0fff;
  localparam logic [15:0] ODRS_AMP_BYP_RST = 16'h3333;
  localparam logic [15:0] ODRS_AMP_BYP_MASK = 16'hffff;
  localparam logic [15:0] ODRS_CTRL_RST = 16'h0000;
  localparam logic [15:0] ODRS_CTRL_MASK = 16'h00ff;
  // control bits
  localparam int ODRS_CTRL_A_SIL = 0;
  localparam int ODRS_CTRL_A_OFF = 1;
  localparam int ODRS_CTRL_B_SIL = 2;
  localparam int ODRS_CTRL_B_OFF = 3;
  localparam int ODRS_CTRL_MAN_EN = 4;
  localparam int ODRS_CTRL_MAN_LSB = 5;
  // status bits
  localparam int ODRS_STAT_RATE_LSB = 0;
  localparam int ODRS_STAT_LOCK = 3;
  localparam int ODRS_STAT_A_EMPH_LSB = 4;
  localparam int ODRS_STAT_A_AMP_LSB = 7;
  localparam int ODRS_STAT_B_EMPH_LSB = 11;
  // rate codes
  localparam logic [2:0] ODRS_RATE_AUDIO = 3'h0;
  localparam logic [2:0] ODRS_RATE_SD = 3'h1;
  localparam logic [2:0] ODRS_RATE_HD = 3'h2;
  localparam logic [2:0] ODRS_RATE_3G = 3'h3;
  localparam logic [2:0] ODRS_RATE_6G = 3'h4;

  typedef struct packed {
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [15:0] emph_a;
    logic [15:0] emph_b;
    logic [15:0] amp_low;
    logic [15:0] amp_byp;
    logic [15:0] ctrl;
    logic lock_s1;
    logic lock_s2;
    logic [2:0] rate_s1;
    logic [2:0] rate_s2;
    logic [2:0] a_emph;
    logic [3:0] a_amp;
    logic a_sil;
    logic a_off;
    logic [2:0] b_emph;
    logic b_sil;
    logic b_off;
  } odrs_state_s;
endpackage

// File: rtl/odrs_top.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module odrs_top
  import odrs_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic locked_i,
  input wire logic [2:0] rate_i,
  output logic [2:0] serial_out_a_emph_o,
  output logic [3:0] serial_out_a_amp_o,
  output logic serial_out_a_silence_o,
  output logic serial_out_a_off_o,
  output logic [2:0] serial_out_b_emph_o,
  output logic out_b_silence_o,
  output logic out_b_off_o
);
  // the register decode needs a full byte of address
  if (ADR_W < 8) begin : g_adr_check
    $error("odrs_top: ADR_W must be at least 8");
  end

  odrs_state_s st_r;
  odrs_state_s st_nxt;

  function automatic logic [15:0] odrs_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & mask;
  endfunction

  function automatic logic [2:0] odrs_emph_pick(input logic [15:0] r, input logic [2:0] rate);
    case (rate)
      ODRS_RATE_6G: return r[ODRS_EMPH_6G_LSB +: 3];
      ODRS_RATE_3G: return r[ODRS_EMPH_3G_LSB +: 3];
      ODRS_RATE_HD: return r[ODRS_EMPH_HD_LSB +: 3];
      ODRS_RATE_SD: return r[ODRS_EMPH_SD_LSB +: 3];
      default: return r[ODRS_EMPH_AUDIO_LSB +: 3];
    endcase
  endfunction

  logic req;
  logic upper_zero;
  logic [7:0] widx;
  logic [2:0] eff_rate;
  logic [3:0] rate_amp;
  logic [15:0] stat;

  always_comb begin
    st_nxt = st_r;
    req = wb_cyc_i && wb_stb_i && !st_r.wb_ack;
    upper_zero = (ADR_W == 8) ? 1'b1 : (wb_adr_i >> 8) == '0;
    widx = {2'b00, wb_adr_i[7:2]};
    // pin synchronisers for the lock and rate indications
    st_nxt.lock_s1 = locked_i;
    st_nxt.lock_s2 = st_r.lock_s1;
    st_nxt.rate_s1 = rate_i;
    st_nxt.rate_s2 = st_r.rate_s1;
    eff_rate = st_r.ctrl[ODRS_CTRL_MAN_EN] ? st_r.ctrl[ODRS_CTRL_MAN_LSB +: 3]
                                           : st_r.rate_s2;
    case (eff_rate)
      ODRS_RATE_6G: rate_amp = st_r.amp_byp[ODRS_AMP_6G_LSB +: 4];
      ODRS_RATE_3G: rate_amp = st_r.amp_byp[ODRS_AMP_3G_LSB +: 4];
      ODRS_RATE_HD: rate_amp = st_r.amp_low[ODRS_AMP_HD_LSB +: 4];
      ODRS_RATE_SD: rate_amp = st_r.amp_low[ODRS_AMP_SD_LSB +: 4];
      default: rate_amp = st_r.amp_low[ODRS_AMP_AUDIO_LSB +: 4];
    endcase
    // output a swing code: silence beats passthrough, passthrough beats rate
    st_nxt.a_emph = odrs_emph_pick(st_r.emph_a, eff_rate);
    if (st_r.ctrl[ODRS_CTRL_A_SIL]) begin
      st_nxt.a_amp = st_r.amp_byp[ODRS_AMP_SIL_LSB +: 4];
    end else if (!st_r.lock_s2) begin
      st_nxt.a_amp = st_r.amp_byp[ODRS_AMP_PASS_LSB +: 4];
    end else begin
      st_nxt.a_amp = rate_amp;
    end
    st_nxt.a_off = st_r.ctrl[ODRS_CTRL_A_OFF];
    st_nxt.a_sil = st_r.ctrl[ODRS_CTRL_A_SIL] && !st_r.ctrl[ODRS_CTRL_A_OFF];
    st_nxt.b_emph = odrs_emph_pick(st_r.emph_b, eff_rate);
    st_nxt.b_off = st_r.ctrl[ODRS_CTRL_B_OFF];
    st_nxt.b_sil = st_r.ctrl[ODRS_CTRL_B_SIL] && !st_r.ctrl[ODRS_CTRL_B_OFF];
    stat = '0;
    stat[ODRS_STAT_RATE_LSB +: 3] = eff_rate;
    stat[ODRS_STAT_LOCK] = st_r.lock_s2;
    stat[ODRS_STAT_A_EMPH_LSB +: 3] = st_r.a_emph;
    stat[ODRS_STAT_A_AMP_LSB +: 4] = st_r.a_amp;
    stat[ODRS_STAT_B_EMPH_LSB +: 3] = st_r.b_emph;
    // wishbone classic slave: one wait state, ack held for one cycle
    st_nxt.wb_ack = req;
    st_nxt.wb_dat = '0;
    if (req && upper_zero) begin
      if (wb_we_i) begin
        case (widx)
          ODRS_IDX_EMPH_A:
            st_nxt.emph_a = odrs_merge(st_r.emph_a, wb_dat_i, wb_sel_i,
                                       ODRS_EMPH_MASK);
          ODRS_IDX_EMPH_B:
            st_nxt.emph_b = odrs_merge(st_r.emph_b, wb_dat_i, wb_sel_i,
                                       ODRS_EMPH_MASK);
          ODRS_IDX_AMP_LOW:
            st_nxt.amp_low = odrs_merge(st_r.amp_low, wb_dat_i, wb_sel_i,
                                        ODRS_AMP_LOW_MASK);
          ODRS_IDX_AMP_BYP:
            st_nxt.amp_byp = odrs_merge(st_r.amp_byp, wb_dat_i, wb_sel_i, ODRS_AMP_BYP_MASK);
          ODRS_IDX_CTRL:
            st_nxt.ctrl = odrs_merge(st_r.ctrl, wb_dat_i, wb_sel_i, ODRS_CTRL_MASK);
          default: ;
        endcase
      end else begin
        case (widx)
          ODRS_IDX_EMPH_A: st_nxt.wb_dat = {16'h0000, st_r.emph_a};
          ODRS_IDX_EMPH_B: st_nxt.wb_dat = {16'h0000, st_r.emph_b};
          ODRS_IDX_AMP_LOW: st_nxt.wb_dat = {16'h0000, st_r.amp_low};
          ODRS_IDX_AMP_BYP: st_nxt.wb_dat = {16'h0000, st_r.amp_byp};
          ODRS_IDX_CTRL: st_nxt.wb_dat = {16'h0000, st_r.ctrl};
          ODRS_IDX_STAT: st_nxt.wb_dat = {16'h0000, stat};
          default: st_nxt.wb_dat = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.emph_a <= ODRS_EMPH_RST;
      st_r.emph_b <= ODRS_EMPH_RST;
      st_r.amp_low <= ODRS_AMP_LOW_RST;
      st_r.amp_byp <= ODRS_AMP_BYP_RST;
      st_r.ctrl <= ODRS_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.wb_dat;
  assign wb_ack_o = st_r.wb_ack;
  assign serial_out_a_emph_o = st_r.a_emph;
  assign serial_out_a_amp_o = st_r.a_amp;
  assign serial_out_a_silence_o = st_r.a_sil;
  assign serial_out_a_off_o = st_r.a_off;
  assign serial_out_b_emph_o = st_r.b_emph;
  assign out_b_silence_o = st_r.b_sil;
  assign out_b_off_o = st_r.b_off;
endmodule
`default_nettype wire

// File: testbench/odrs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module odrs_checker #(
  parameter int ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_out_a_silence_o,
  input wire logic serial_out_a_off_o,
  input wire logic out_b_silence_o,
  input wire logic out_b_off_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(a);
    wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  sequence s_ctl_wr;
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h80;
  endsequence
  a_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_dat_idle:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  a_emph_reserved_bits:
    assert property (s_rd(8'h68) |-> !wb_dat_o[15]) else $error("emph reserved");
  a_amp_reserved_bits:
    assert property (s_rd(8'h70) |-> wb_dat_o[15:12] == 4'h0) else $error("amp reserved");
  a_a_off_set:
    assert property (s_ctl_wr |=> serial_out_a_off_o == $past(wb_dat_i[1])) else $error("a off");
  a_a_sil_set:
    assert property (s_ctl_wr |=> serial_out_a_silence_o == ($past(wb_dat_i[0])
      && !$past(wb_dat_i[1]))) else $error("a silence");
  a_off_wins:
    assert property (!(serial_out_a_off_o && serial_out_a_silence_o)
      && !(out_b_off_o && out_b_silence_o)) else $error("off and silence");
endmodule
bind odrs_top odrs_checker #(.ADR_W(ADR_W)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_out_a_silence_o(serial_out_a_silence_o), .serial_out_a_off_o(serial_out_a_off_o),
  .out_b_silence_o(out_b_silence_o), .out_b_off_o(out_b_off_o));
`default_nettype wire

// File: testbench/odrs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module odrs_top_tb;
  logic clk_i, rst_i, cyc, stb, we, ack, locked, a_sil, a_off, b_sil, b_off;
  logic [7:0] adr;
  logic [3:0] sel, a_amp;
  logic [31:0] wdat, rdat;
  logic [2:0] rate, a_emph, b_emph;
  int n_fail, checks;
  odrs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .locked_i(locked), .rate_i(rate), .serial_out_a_emph_o(a_emph),
    .serial_out_a_amp_o(a_amp), .serial_out_a_silence_o(a_sil), .serial_out_a_off_o(a_off),
    .serial_out_b_emph_o(b_emph), .out_b_silence_o(b_sil), .out_b_off_o(b_off));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      $display("BAD ack exp 1 got %b", ack);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    acc(1'b0, a, 16'h0, q);
    chk(nm, e, q);
  endtask
  task automatic t_reset;
    rd_chk("emph_a", 8'h68, 16'h2240);
    rd_chk("emph_b", 8'h6c, 16'h2240);
    rd_chk("amp_low", 8'h70, 16'h0333);
    rd_chk("amp_byp", 8'h74, 16'h3333);
    chk("amp_a", 16'h3, 16'(a_amp));
  endtask
  task automatic t_mask;
    wr(8'h68, 16'hffff);
    rd_chk("emph_a", 8'h68, 16'h7fff);
    rd_chk("emph_b", 8'h6c, 16'h2240);
    // low byte lane only: the upper byte must keep its reset value
    sel <= 4'h1;
    wr(8'h6c, 16'h7fff);
    sel <= 4'h3;
    rd_chk("emph_b_lane", 8'h6c, 16'h22ff);
    wr(8'h70, 16'hffff);
    rd_chk("amp_low", 8'h70, 16'h0fff);
    rd_chk("unmapped", 8'h60, 16'h0);
  endtask
  // per-rate expectations indexed by rate code audio, sd, hd, 3g, 6g
  task automatic t_rates;
    logic [2:0] ea [5] = '{3'h6, 3'h5, 3'h2, 3'h3, 3'h4};
    logic [2:0] eb [5] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
    logic [3:0] aa [5] = '{4'h7, 4'h6, 4'h5, 4'hc, 4'hb};
    wr(8'h68, 16'h46ae);
    wr(8'h6c, 16'h14e5);
    wr(8'h70, 16'h0567);
    wr(8'h74, 16'h9abc);
    locked <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      rate <= 3'(r);
      repeat (4) @(posedge clk_i);
      chk("emph_a", 16'(ea[r]), 16'(a_emph));
      chk("emph_b", 16'(eb[r]), 16'(b_emph));
      chk("amp_a", 16'(aa[r]), 16'(a_amp));
    end
    // manual rate choice (hd) overrides the detected 6g rate while locked
    wr(8'h80, 16'h0050);
    repeat (2) @(posedge clk_i);
    chk("man_emph_a", 16'h2, 16'(a_emph));
    chk("man_emph_b", 16'h3, 16'(b_emph));
    chk("man_amp_a", 16'h5, 16'(a_amp));
    rd_chk("ctrl", 8'h80, 16'h0050);
    rd_chk("stat", 8'h84, 16'h1aaa);
    wr(8'h80, 16'h0000);
    locked <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("amp_pass", 16'h9, 16'(a_amp));
  endtask
  task automatic t_mute;
    wr(8'h80, 16'h1);
    repeat (2) @(posedge clk_i);
    chk("amp_sil", 16'ha, 16'(a_amp));
    wr(8'h80, 16'h3);
    repeat (2) @(posedge clk_i);
    chk("a_off_sil", 16'h2, 16'({a_off, a_sil}));
    wr(8'h80, 16'hc);
    repeat (2) @(posedge clk_i);
    chk("b_off_sil", 16'h2, 16'({b_off, b_sil}));
    wr(8'h80, 16'h4);
    repeat (2) @(posedge clk_i);
    chk("b_off_sil", 16'h1, 16'({b_off, b_sil}));
  endtask
  initial begin
    rst_i <= 1'b1;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= 8'h0;
    sel <= 4'h3;
    wdat <= 32'h0;
    locked <= 1'b0;
    rate <= 3'h0;
    n_fail = 0;
    checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_mask();
    t_rates();
    t_mute();
    end_sim();
  end
endmodule
`default_nettype wire
